// [verilog/slsc_pkg.sv]
/*
 package of the loop station control block: register offsets, field
 positions, reset values, bit patterns and the bus answer codes.
 assumes nothing of its surroundings.
*/
package slsc_pkg;
   // register byte offsets
   localparam logic [7:0] SLSC_MISC_CTRL_OFS   = 8'h00;
   localparam logic [7:0] SLSC_MISC_STAT_OFS   = 8'h04;
   localparam logic [7:0] SLSC_PRIM_STAT_OFS   = 8'h08;
   localparam logic [7:0] SLSC_TX_CTRL_OFS     = 8'h0C;
   localparam logic [7:0] SLSC_TX_DATA_OFS     = 8'h10;
   localparam logic [7:0] SLSC_COMMAND_OFS     = 8'h14;
   // misc_control_reg fields
   localparam int SLSC_LOOP_SEL_BIT     = 1;
   localparam int SLSC_UNDER_ABORT_BIT  = 2;
   localparam int SLSC_MARK_IDLE_BIT    = 3;
   localparam int SLSC_GO_ACTIVE_BIT    = 4;
   localparam int SLSC_NRZI_BIT         = 5;
   // misc_status_reg fields
   localparam int SLSC_ON_LOOP_BIT      = 1;
   localparam int SLSC_LOOP_SEND_BIT    = 4;
   // primary_status_reg fields
   localparam int SLSC_TX_EMPTY_BIT     = 2;
   localparam int SLSC_HUNT_BIT         = 4;
   localparam int SLSC_BREAK_BIT        = 7;
   // tx_control_reg fields
   localparam int SLSC_TX_EN_BIT        = 3;
   // command_reg fields
   localparam int SLSC_CLR_BREAK_BIT    = 0;
   localparam int SLSC_END_FRAME_BIT    = 1;
   // reset values
   localparam logic [7:0] SLSC_MISC_CTRL_RST = 8'h00;
   localparam logic [7:0] SLSC_TX_CTRL_RST   = 8'h00;
   // line patterns
   localparam logic [7:0] SLSC_FLAG          = 8'h7E;
   localparam logic [7:0] SLSC_EOP_RX        = 8'hFE;
   localparam int         SLSC_ONES_FOR_EOP  = 7;
   localparam int         SLSC_STUFF_RUN     = 5;
   // bus answers
   localparam logic [1:0] SLSC_RESP_OKAY     = 2'b00;
   localparam logic [1:0] SLSC_RESP_SLVERR   = 2'b10;
endpackage

// [verilog/slsc_sync.sv]
/*
 two flip-flop synchroniser for a level arriving from outside.
 assumes one clock and a synchronous active high reset.
*/
`timescale 1ns/10ps
module slsc_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] stage1;

   always_ff @(posedge clk) begin
      if (rst) begin
         stage1 <= '0;
         q      <= '0;
      end else begin
         stage1 <= d;
         q      <= stage1;
      end
   end
endmodule

// [verilog/slsc_tx_shifter.sv]
/*
 transmit shifter with zero-bit insertion: sends flags, eop patterns
 and data bytes lsb first, one bit per bit enable.
 assumes bit_en comes one cycle per line bit from the station logic.
*/
`timescale 1ns/10ps
module slsc_tx_shifter
   import slsc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       bit_en,
   input  wire logic       load,
   input  wire logic [7:0] load_byte,
   input  wire logic       load_stuff,
   input  wire logic [3:0] load_len,
   output logic            tx_bit,
   output logic            empty
);
   logic [7:0] shreg;
   logic [3:0] left;
   logic       stuff_on;
   logic [2:0] ones_run;
   logic       stuffing;

   assign stuffing = stuff_on && ones_run == 3'(SLSC_STUFF_RUN);
   assign empty    = left == 4'h0 && !stuffing;

   // **************************************************
   // shift and zero-bit insertion
   // **************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         shreg    <= 8'hFF;
         left     <= 4'h0;
         stuff_on <= 1'b0;
         ones_run <= 3'h0;
         tx_bit   <= 1'b1;
      end else if (load && empty) begin
         shreg    <= load_byte;
         left     <= load_len;
         stuff_on <= load_stuff;
         if (!load_stuff) begin
            ones_run <= 3'h0;
         end
      end else if (bit_en) begin
         if (stuffing) begin
            tx_bit   <= 1'b0;
            ones_run <= 3'h0;
         end else if (left != 4'h0) begin
            tx_bit   <= shreg[0];
            shreg    <= {1'b1, shreg[7:1]};
            left     <= left - 4'h1;
            ones_run <= shreg[0] ? ones_run + 3'h1 : 3'h0;
         end
      end
   end
endmodule

// [verilog/slsc_station.sv]
/*
 secondary station control of an sdlc loop: relays the line, goes on
 and off the loop, turns an end-of-poll into a flag and inserts frames.
 assumes an axi4-lite master on SYS_CLK, RX_CLK and RX_DATA from the
 line, and that the host follows the loop start sequence.
*/
`timescale 1ns/10ps
module slsc_station
   import slsc_pkg::*;
(
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic        RX_CLK,
   input  wire logic        RX_DATA,
   output logic             TX_DATA,
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY
);
   typedef enum logic [2:0] {
      SLSC_DIRECT  = 3'b000,
      SLSC_SEARCH  = 3'b001,
      SLSC_HUNT    = 3'b010,
      SLSC_ARMED   = 3'b011,
      SLSC_SENDING = 3'b100,
      SLSC_CLOSING = 3'b101
   } slsc_state_e;

   slsc_state_e state;
   logic [7:0]  misc_control_reg;
   logic [7:0]  tx_control_reg;
   logic [7:0]  tx_buf;
   logic        tx_full;
   logic        brk;
   logic        hunt;
   logic        on_loop;
   logic        loop_send;
   logic        delay_on;
   logic        go_send;
   logic        last_out;
   logic        last_rx;
   logic [1:0]  rx_pins;
   logic        clk_s;
   logic        rx_s;
   logic        clk_d;
   logic        bit_en;
   logic [7:0]  rx_win;
   logic [2:0]  ones_cnt;
   logic        eop_seen;
   logic        flag_seen;
   logic        seven_ones;
   logic        sh_bit;
   logic        sh_empty;
   logic        sh_load;
   logic [7:0]  sh_byte;
   logic        sh_stuff;
   logic [3:0]  sh_len;
   logic        loop_sel;
   logic        go_active;
   logic        flag_pend;
   logic        eop_pend;
   logic        data_seen;
   logic        aw_held;
   logic        w_held;
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        wr_go;
   logic [7:0]  next_rdata;

   assign loop_sel  = misc_control_reg[SLSC_LOOP_SEL_BIT];
   assign go_active = misc_control_reg[SLSC_GO_ACTIVE_BIT];

   // **************************************************
   // line input sampling
   // **************************************************
   slsc_sync #(.WIDTH(2)) u_sync (
      .clk (SYS_CLK),
      .rst (RST),
      .d   ({RX_CLK, RX_DATA}),
      .q   (rx_pins)
   );
   assign clk_s  = rx_pins[1];
   assign rx_s   = rx_pins[0];
   assign bit_en = clk_s && !clk_d;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         clk_d <= 1'b0;
      end else begin
         clk_d <= clk_s;
      end
   end

   // **************************************************
   // receive pattern detection
   // **************************************************
   assign seven_ones = rx_s && ones_cnt == 3'(SLSC_ONES_FOR_EOP - 1);
   assign eop_seen   = {rx_s, rx_win[7:1]} == SLSC_EOP_RX;
   assign flag_seen  = {rx_s, rx_win[7:1]} == SLSC_FLAG;
   assign go_send    = state == SLSC_ARMED && eop_seen && loop_sel &&
                       go_active;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rx_win   <= 8'h00;
         ones_cnt <= 3'h0;
      end else if (bit_en) begin
         rx_win   <= {rx_s, rx_win[7:1]};
         if (!rx_s || state != SLSC_SEARCH) begin
            ones_cnt <= 3'h0;
         end else if (ones_cnt != 3'(SLSC_ONES_FOR_EOP - 1)) begin
            ones_cnt <= ones_cnt + 3'h1;
         end
      end
   end

   // **************************************************
   // relay path and one-bit delay
   // **************************************************
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         last_rx   <= 1'b1;
      end else if (bit_en) begin
         last_rx   <= rx_s;
      end
   end

   // final eop one is forced to zero when sending starts
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         TX_DATA  <= 1'b1;
         last_out <= 1'b1;
      end else if (!delay_on) begin
         TX_DATA  <= rx_s;
      end else if (bit_en) begin
         if (go_send) begin
            TX_DATA <= 1'b0;
         end else if (loop_send) begin
            TX_DATA <= sh_bit;
         end else begin
            TX_DATA <= rx_s;
         end
         last_out <= TX_DATA;
      end
   end

   // **************************************************
   // loop state machine
   // **************************************************
   always_ff @(posedge SYS_CLK) begin
      if (RST || !tx_control_reg[SLSC_TX_EN_BIT]) begin
         state     <= SLSC_DIRECT;
         delay_on  <= 1'b0;
         on_loop   <= 1'b0;
         hunt      <= 1'b0;
         loop_send <= 1'b0;
         flag_pend <= 1'b0;
         eop_pend  <= 1'b0;
         data_seen <= 1'b0;
      end else begin
         unique case (state)
            SLSC_DIRECT: begin
               if (loop_sel && go_active) begin
                  state <= SLSC_SEARCH;
               end
            end
            SLSC_SEARCH: begin
               if (!loop_sel) begin
                  state <= SLSC_DIRECT;
               end else if (bit_en && seven_ones) begin
                  state    <= SLSC_HUNT;
                  delay_on <= 1'b1;
                  on_loop  <= 1'b1;
                  hunt     <= 1'b1;
               end
            end
            SLSC_HUNT: begin
               if (bit_en && flag_seen) begin
                  hunt  <= 1'b0;
                  state <= SLSC_ARMED;
               end
            end
            SLSC_ARMED: begin
               if (bit_en && eop_seen) begin
                  if (!loop_sel) begin
                     state    <= SLSC_DIRECT;
                     delay_on <= 1'b0;
                     on_loop  <= 1'b0;
                     hunt     <= 1'b1;
                  end else if (go_active) begin
                     state     <= SLSC_SENDING;
                     loop_send <= 1'b1;
                     hunt      <= 1'b1;
                     flag_pend <= sh_empty;
                     data_seen <= 1'b0;
                  end
               end
            end
            SLSC_SENDING: begin
               if (sh_load && !flag_pend && tx_full) begin
                  data_seen <= 1'b1;
               end
               if (sh_load && flag_pend) begin
                  flag_pend <= 1'b0;
               end
               if (sh_load && !tx_full && data_seen && !go_active) begin
                  state    <= SLSC_CLOSING;
                  eop_pend <= 1'b1;
               end else if (sh_load && !tx_full && !loop_sel) begin
                  state    <= SLSC_CLOSING;
                  eop_pend <= 1'b1;
               end
            end
            SLSC_CLOSING: begin
               if (sh_load) begin
                  eop_pend <= 1'b0;
               end
               if (!eop_pend && sh_empty) begin
                  loop_send <= 1'b0;
                  state     <= SLSC_ARMED;
               end
            end
            default: begin
               state <= SLSC_DIRECT;
            end
         endcase
      end
   end

   // **************************************************
   // transmit shifter feed
   // **************************************************
   always_comb begin
      sh_load  = 1'b0;
      sh_byte  = SLSC_FLAG;
      sh_stuff = 1'b0;
      sh_len   = 4'h8;
      if (sh_empty && !delay_on) begin
         sh_load = loop_sel;
      end else if (sh_empty && state == SLSC_SENDING) begin
         sh_load = 1'b1;
         if (!flag_pend && tx_full) begin
            sh_byte  = tx_buf;
            sh_stuff = 1'b1;
         end
      end else if (sh_empty && state == SLSC_CLOSING && eop_pend) begin
         sh_load = 1'b1;
         // closing flag then eop sharing its zero; on nrzi parity mismatch a flag instead of the seven ones
         if (misc_control_reg[SLSC_NRZI_BIT] && last_out != last_rx) begin
            sh_byte = SLSC_FLAG;
         end else begin
            sh_byte = 8'hFF;
            sh_len  = 4'h7;
         end
      end
   end

   slsc_tx_shifter u_shift (
      .clk        (SYS_CLK),
      .rst        (RST),
      .bit_en     (bit_en && (loop_send || go_send)),
      .load       (sh_load),
      .load_byte  (sh_byte),
      .load_stuff (sh_stuff),
      .load_len   (sh_len),
      .tx_bit     (sh_bit),
      .empty      (sh_empty)
   );

   // **************************************************
   // axi4-lite write channel
   // **************************************************
   assign wr_go = aw_held && w_held && !S_AXI_BVALID;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= SLSC_RESP_OKAY;
      end else begin
         S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY && S_AXI_AWVALID;
         S_AXI_WREADY  <= !w_held && !S_AXI_WREADY && S_AXI_WVALID;
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_held <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end
         if (wr_go) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            unique case (aw_addr)
               SLSC_MISC_CTRL_OFS, SLSC_TX_CTRL_OFS, SLSC_TX_DATA_OFS,
               SLSC_COMMAND_OFS: S_AXI_BRESP <= SLSC_RESP_OKAY;
               default:          S_AXI_BRESP <= SLSC_RESP_SLVERR;
            endcase
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // **************************************************
   // software registers
   // **************************************************
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         misc_control_reg <= SLSC_MISC_CTRL_RST;
         tx_control_reg   <= SLSC_TX_CTRL_RST;
      end else if (wr_go && w_strb[0]) begin
         if (aw_addr == SLSC_MISC_CTRL_OFS) begin
            misc_control_reg <= w_data[7:0];
         end
         if (aw_addr == SLSC_TX_CTRL_OFS) begin
            tx_control_reg <= w_data[7:0];
         end
      end
   end

   // set wins over clear on break status
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         brk     <= 1'b0;
         tx_full <= 1'b0;
         tx_buf  <= 8'h00;
      end else begin
         if (bit_en && ((state == SLSC_SEARCH && seven_ones) ||
             (state == SLSC_ARMED && eop_seen))) begin
            brk <= 1'b1;
         end else if (wr_go && w_strb[0] && aw_addr == SLSC_COMMAND_OFS &&
                      w_data[SLSC_CLR_BREAK_BIT]) begin
            brk <= 1'b0;
         end
         if (wr_go && w_strb[0] && aw_addr == SLSC_TX_DATA_OFS) begin
            tx_buf  <= w_data[7:0];
            tx_full <= 1'b1;
         end else if (sh_load && state == SLSC_SENDING && !flag_pend) begin
            tx_full <= 1'b0;
         end
      end
   end

   // **************************************************
   // axi4-lite read channel
   // **************************************************
   always_comb begin
      next_rdata = 8'h00;
      unique case (S_AXI_ARADDR)
         SLSC_MISC_CTRL_OFS: next_rdata = misc_control_reg;
         SLSC_TX_CTRL_OFS:   next_rdata = tx_control_reg;
         SLSC_MISC_STAT_OFS: begin
            next_rdata[SLSC_ON_LOOP_BIT]   = on_loop;
            next_rdata[SLSC_LOOP_SEND_BIT] = loop_send;
         end
         SLSC_PRIM_STAT_OFS: begin
            next_rdata[SLSC_BREAK_BIT]    = brk;
            next_rdata[SLSC_HUNT_BIT]     = hunt;
            next_rdata[SLSC_TX_EMPTY_BIT] = !tx_full;
         end
         default: next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h0000_0000;
         S_AXI_RRESP   <= SLSC_RESP_OKAY;
      end else begin
         S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
         if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= {24'h00_0000, next_rdata};
            unique case (S_AXI_ARADDR)
               SLSC_MISC_CTRL_OFS, SLSC_TX_CTRL_OFS, SLSC_MISC_STAT_OFS,
               SLSC_PRIM_STAT_OFS: S_AXI_RRESP <= SLSC_RESP_OKAY;
               default:            S_AXI_RRESP <= SLSC_RESP_SLVERR;
            endcase
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end
endmodule

// [test/slsc_station_props.sv]
/*
 checker of the loop station: bus answers, status fields and the
 direct relay before go-active.
 assumes it is bound to the station top and sees only its ports.
*/
`timescale 1ns/10ps
module slsc_station_props
   import slsc_pkg::*;
(
   input wire logic        SYS_CLK,
   input wire logic        RST,
   input wire logic        RX_DATA,
   input wire logic        TX_DATA,
   input wire logic [7:0]  S_AXI_AWADDR,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic        S_AXI_BVALID,
   input wire logic [7:0]  S_AXI_ARADDR,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic [31:0] S_AXI_RDATA,
   input wire logic        S_AXI_RVALID,
   input wire logic        S_AXI_RREADY
);
   logic       ga_seen;
   logic [2:0] cnt;
   logic [7:0] rd_ofs;
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   // ********************************
   // helpers: go-active seen, read place
   // ********************************
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         ga_seen <= 1'b0;
         cnt     <= 3'd0;
      end else begin
         if (cnt != 3'd7) cnt <= cnt + 3'd1;
         if (S_AXI_WVALID && S_AXI_WREADY && S_AXI_WDATA[SLSC_GO_ACTIVE_BIT]
             && S_AXI_AWADDR == SLSC_MISC_CTRL_OFS) ga_seen <= 1'b1;
      end
   end
   always_ff @(posedge SYS_CLK) begin
      if (RST) rd_ofs <= 8'h00;
      else if (S_AXI_ARVALID && S_AXI_ARREADY) rd_ofs <= S_AXI_ARADDR;
   end
   property p_relay;
      cnt == 3'd7 && !ga_seen |-> TX_DATA == $past(RX_DATA, 3);
   endproperty
   property p_wr;
      S_AXI_AWVALID && S_AXI_AWREADY |-> ##[1:3] S_AXI_BVALID;
   endproperty
   property p_rd;
      S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID
         && S_AXI_RDATA[31:8] == 24'h00_0000;
   endproperty
   property p_rdone;
      S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID;
   endproperty
   property p_stat;
      S_AXI_RVALID && rd_ofs == SLSC_MISC_STAT_OFS
         |-> (S_AXI_RDATA & ~32'h0000_0012) == 32'h0000_0000;
   endproperty
   property p_prim;
      S_AXI_RVALID && rd_ofs == SLSC_PRIM_STAT_OFS
         |-> (S_AXI_RDATA & ~32'h0000_0094) == 32'h0000_0000;
   endproperty
   property p_onloop;
      S_AXI_RVALID && rd_ofs == SLSC_MISC_STAT_OFS
         && S_AXI_RDATA[SLSC_ON_LOOP_BIT] |-> ga_seen;
   endproperty
   property p_send;
      S_AXI_RVALID && rd_ofs == SLSC_MISC_STAT_OFS
         && S_AXI_RDATA[SLSC_LOOP_SEND_BIT] |-> ga_seen;
   endproperty
   a_relay: assert property (p_relay)
      else $error("direct relay broken");
   a_wr: assert property (p_wr)
      else $error("write answer late");
   a_rd: assert property (p_rd)
      else $error("read answer wrong");
   a_rdone: assert property (p_rdone)
      else $error("read answer held");
   a_stat: assert property (p_stat)
      else $error("misc status stray bit");
   a_prim: assert property (p_prim)
      else $error("primary status stray bit");
   a_onloop: assert property (p_onloop)
      else $error("on loop without go active");
   a_send: assert property (p_send)
      else $error("sending without go active");
   c_onloop: cover property (p_onloop);
   c_ga: cover property (ga_seen && cnt == 3'd7);
   c_wr: cover property (S_AXI_AWVALID && S_AXI_AWREADY);
endmodule

bind slsc_station slsc_station_props slsc_station_props_i (
   .SYS_CLK(SYS_CLK), .RST(RST), .RX_DATA(RX_DATA), .TX_DATA(TX_DATA),
   .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID),
   .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
   .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARADDR(S_AXI_ARADDR),
   .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
   .S_AXI_RREADY(S_AXI_RREADY));

// [test/slsc_line_model.sv]
/*
 upstream loop station: clocks bytes onto the line and samples the
 station output just before each receive clock rise.
 assumes the bench clock; the line marks idle between bytes.
*/
`timescale 1ns/10ps
module slsc_line_model (
   input  wire logic clk,
   input  wire logic tx_data,
   output logic      rx_clk,
   output logic      rx_data
);
   logic seen[$];
   initial begin
      rx_clk = 1'b1;
      rx_data = 1'b1;
   end
   // one byte lsb first, twelve cycles a bit
   task automatic send(input logic [7:0] b);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         rx_clk  <= 1'b0;
         rx_data <= b[i];
         repeat (6) @(posedge clk);
         seen.push_back(tx_data);
         rx_clk <= 1'b1;
         repeat (5) @(posedge clk);
      end
      rx_data <= 1'b1;
   endtask
endmodule

// [test/tb_slsc_station.sv]
/*
 bench of the loop station: axi4-lite tasks and byte checks of what
 the station relays and inserts on the line.
 assumes the checker is bound from its own file.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
   bad_count++; $display("Error %s expected %h seen %h", n, e, g); \
   end end
module tb_slsc_station
   import slsc_pkg::*;
;
   logic        SYS_CLK = 1'b0;
   logic        RST;
   logic        rx_clk, rx_data, tx_data, awready, wready, bvalid;
   logic        arready, rvalid, awvalid, wvalid;
   logic        bready, arvalid, rready;
   logic [7:0]  awaddr, araddr;
   logic [3:0]  wstrb;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   int          bad_count = 0, comparisons = 0;
   always #2 SYS_CLK = ~SYS_CLK;
   slsc_line_model slsc_line_model_i (.clk(SYS_CLK), .tx_data(tx_data),
      .rx_clk(rx_clk), .rx_data(rx_data));
   slsc_station slsc_station_i (.SYS_CLK(SYS_CLK), .RST(RST),
      .RX_CLK(rx_clk), .RX_DATA(rx_data), .TX_DATA(tx_data),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready));
   // ********************************
   // bus and line tasks
   // ********************************
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] er);
      @(posedge SYS_CLK);
      awaddr  <= a;
      wdata   <= {24'h00_0000, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge SYS_CLK);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      `CHK("bresp", er, bresp)
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er,
                     output logic [31:0] d);
      @(posedge SYS_CLK);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge SYS_CLK); while (!arready);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge SYS_CLK);
      d = rdata;
      rready <= 1'b0;
      `CHK("rresp", er, rresp)
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] d;
      rd(a, SLSC_RESP_OKAY, d);
      `CHK("rdata", {24'h00_0000, e}, d)
   endtask
   task automatic chk8(input int o, input logic [7:0] e);
      logic [7:0] g;
      for (int i = 0; i < 8; i++) g[i] = slsc_line_model_i.seen[o + i];
      `CHK("line byte", e, g)
   endtask
   task automatic end_sim();
      if (bad_count == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (30000) @(posedge SYS_CLK);
      bad_count++;
      end_sim();
   end
   // ********************************
   // scenarios
   // ********************************
   initial begin
      logic [31:0] v;
      RST     <= 1'b1;
      awvalid <= 1'b0;
      wvalid  <= 1'b0;
      bready  <= 1'b0;
      arvalid <= 1'b0;
      rready  <= 1'b0;
      awaddr  <= 8'h00;
      araddr  <= 8'h00;
      wdata   <= 32'h0000_0000;
      wstrb   <= 4'h1;
      repeat (2) @(posedge SYS_CLK);
      RST <= 1'b0;
      rdc(SLSC_MISC_CTRL_OFS, SLSC_MISC_CTRL_RST);
      rdc(SLSC_TX_CTRL_OFS, SLSC_TX_CTRL_RST);
      rdc(SLSC_MISC_STAT_OFS, 8'h00);
      rd(8'h18, SLSC_RESP_SLVERR, v);
      `CHK("unmapped", 32'h0000_0000, v)
      wr(8'h18, 8'h5A, SLSC_RESP_SLVERR);
      wstrb <= 4'hE;
      wr(SLSC_MISC_CTRL_OFS, 8'h02, SLSC_RESP_OKAY);
      wstrb <= 4'h1;
      rdc(SLSC_MISC_CTRL_OFS, SLSC_MISC_CTRL_RST);
      slsc_line_model_i.seen.delete();
      slsc_line_model_i.send(8'h35);
      chk8(0, 8'h35);
      wr(SLSC_MISC_CTRL_OFS, 8'h0E, SLSC_RESP_OKAY);
      rdc(SLSC_MISC_CTRL_OFS, 8'h0E);
      slsc_line_model_i.send(8'hFF);
      slsc_line_model_i.send(8'hFF);
      rdc(SLSC_MISC_STAT_OFS, 8'h00);
      wr(SLSC_TX_CTRL_OFS, 8'h08, SLSC_RESP_OKAY);
      wr(SLSC_MISC_CTRL_OFS, 8'h12, SLSC_RESP_OKAY);
      slsc_line_model_i.send(8'hFF);
      rd(SLSC_PRIM_STAT_OFS, SLSC_RESP_OKAY, v);
      `CHK("break", 1'b1, v[SLSC_BREAK_BIT])
      `CHK("hunt", 1'b1, v[SLSC_HUNT_BIT])
      rdc(SLSC_MISC_STAT_OFS, 8'h02);
      wr(SLSC_COMMAND_OFS, 8'h01, SLSC_RESP_OKAY);
      slsc_line_model_i.send(SLSC_FLAG);
      rd(SLSC_PRIM_STAT_OFS, SLSC_RESP_OKAY, v);
      `CHK("hunt", 1'b0, v[SLSC_HUNT_BIT])
      `CHK("break", 1'b0, v[SLSC_BREAK_BIT])
      slsc_line_model_i.seen.delete();
      slsc_line_model_i.send(8'h55);
      chk8(0, 8'hAA);
      wr(SLSC_TX_DATA_OFS, 8'hA5, SLSC_RESP_OKAY);
      slsc_line_model_i.send(SLSC_FLAG);
      slsc_line_model_i.seen.delete();
      slsc_line_model_i.send(8'hFF);
      fork
         repeat (5) slsc_line_model_i.send(8'hFF);
         wr(SLSC_MISC_CTRL_OFS, 8'h02, SLSC_RESP_OKAY);
      join
      chk8(0, SLSC_FLAG);
      chk8(8, SLSC_FLAG);
      chk8(16, 8'hA5);
      chk8(24, SLSC_FLAG);
      chk8(32, 8'hFF);
      rdc(SLSC_MISC_STAT_OFS, 8'h02);
      wr(SLSC_COMMAND_OFS, 8'h01, SLSC_RESP_OKAY);
      wr(SLSC_MISC_CTRL_OFS, 8'h00, SLSC_RESP_OKAY);
      slsc_line_model_i.send(SLSC_FLAG);
      slsc_line_model_i.send(8'hFF);
      rdc(SLSC_MISC_STAT_OFS, 8'h00);
      rd(SLSC_PRIM_STAT_OFS, SLSC_RESP_OKAY, v);
      `CHK("break", 1'b1, v[SLSC_BREAK_BIT])
      end_sim();
   end
endmodule
